// >>> lcms_cell_model.sv
// battery cell, thermistor and adapter model facing the charge mode sequencer
module lcms_cell_model #(
   parameter int CV_CYC = 30
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // supply, thermistor and die flags set by the bench
   input wire lcms_pkg::lcms_cmp_t env,
   input wire logic [12:0] cellMv,
   // loop commands from the sequencer
   input wire lcms_pkg::lcms_drive_t drive,
   // comparator outputs to the sequencer
   output lcms_pkg::lcms_cmp_t cmpPins
);
   timeunit 1ns;
   timeprecision 100ps;
   import lcms_pkg::*;

   logic [7:0] cvCnt_reg;

   // taper: current reaches termination a fixed time after the voltage loop closes
   always_ff @(posedge clk) begin
      if (!rst_b || !drive.cvOn) begin
         cvCnt_reg <= 8'h00;
      end else if (cvCnt_reg != 8'hff) begin
         cvCnt_reg <= cvCnt_reg + 8'h01; // saturates, never wraps back above termination
      end
   end

   // cell comparators; supply, thermistor and die flags pass straight through
   always_comb begin
      cmpPins = env;
      cmpPins.belowPrecond = cellMv < 13'h0bb8; // 3000 mV
      cmpPins.atRegulation = cellMv >= drive.regMv;
      cmpPins.belowTerm = drive.cvOn && (cvCnt_reg >= 8'(CV_CYC));
      cmpPins.belowRecharge = cellMv < drive.rchMv;
   end
endmodule // lcms_cell_model

// >>> lcms_charge_sequencer.sv
// charge mode sequencer: start checks, charge modes, faults, leds, status report
`include "lcms_consts.svh"

module lcms_charge_sequencer #(
   parameter logic [11:0] BIT_CYC = 12'(`LCMS_BIT_CYC)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // comparator outputs from the analog front end
   input wire lcms_pkg::lcms_cmp_t cmpPins,
   // open-drain status line
   input wire logic statusIn,
   output logic statusOut,
   output logic statusOe,
   // analog loop commands
   output lcms_pkg::lcms_drive_t drive,
   // indicator leds, low lights
   output logic ledCharge_b,
   output logic ledDone_b
);
   import lcms_pkg::*;

   lcms_seq_state_t cur_reg, cur_next;
   lcms_cmp_t cmp;
   logic healthy;
   logic faultNow;
   logic [3:0] faultCode;
   logic txBusy;
   logic txOe;

   // only the second stage is ever looked at
   assign cmp = cur_reg.sync2;

   // fault causes in priority order
   always_comb begin
      faultNow = 1'b0;
      faultCode = `LCMS_CODE_CHECK;
      if (cmp.overVoltage) begin
         faultNow = 1'b1;
         faultCode = `LCMS_CODE_OVERVOLT;
      end else if (cmp.dieShutdown) begin
         faultNow = 1'b1;
         faultCode = `LCMS_CODE_DIEHOT;
      end else if (!cmp.tempOk) begin
         faultNow = 1'b1;
         faultCode = `LCMS_CODE_CELLTEMP;
      end
   end

   // supply good, enabled and no fault: the only case that may charge
   assign healthy = cmp.adpOk && cmp.enable && !faultNow;

   // next state of the whole sequencer
   always_comb begin
      cur_next = cur_reg;
      cur_next.sync1 = cmpPins;
      cur_next.sync2 = cur_reg.sync1;
      cur_next.reqS1 = !statusIn; // stored as a request so the reset value reads as an idle line
      cur_next.reqS2 = cur_reg.reqS1;

      // supply loss and disable override everything, even faults
      if (!cmp.adpOk) begin
         cur_next.mode = ST_SLEEP;
         cur_next.code = `LCMS_CODE_NOINPUT;
      end else if (!cmp.enable) begin
         cur_next.mode = ST_SLEEP;
         cur_next.code = `LCMS_CODE_DISABLED;
      end else if (faultNow) begin
         cur_next.mode = ST_FAULT;
         cur_next.code = faultCode;
      end else begin
         case (cur_reg.mode)
            ST_SLEEP: begin
               // supply back: reassess the cell from scratch
               cur_next.mode = ST_CHECK;
               cur_next.code = `LCMS_CODE_CHECK;
            end
            ST_FAULT: begin
               // fault gone, resume in the mode the cell calls for
               cur_next.mode = ST_CHECK;
               cur_next.code = `LCMS_CODE_CHECK;
            end
            ST_CHECK: begin
               if (!cmp.cellPresent) begin
                  cur_next.code = `LCMS_CODE_NOCELL;
               end else if (cmp.belowPrecond) begin
                  cur_next.mode = ST_PRECOND;
                  cur_next.code = `LCMS_CODE_PRECOND;
               end else if (cmp.atRegulation) begin
                  cur_next.mode = ST_CONSTV;
                  cur_next.code = `LCMS_CODE_CONSTV;
               end else begin
                  cur_next.mode = ST_FASTCC;
                  cur_next.code = `LCMS_CODE_FASTCC;
               end
            end
            ST_PRECOND: begin
               if (!cmp.belowPrecond) begin
                  cur_next.mode = ST_FASTCC;
                  cur_next.code = `LCMS_CODE_FASTCC;
               end
            end
            ST_FASTCC: begin
               if (cmp.atRegulation) begin
                  cur_next.mode = ST_CONSTV;
                  cur_next.code = `LCMS_CODE_CONSTV;
               end else begin
                  cur_next.code = cur_reg.thermal ? `LCMS_CODE_THERMAL : `LCMS_CODE_FASTCC;
               end
            end
            ST_CONSTV: begin
               if (cmp.belowTerm) begin
                  cur_next.mode = ST_DONE;
                  cur_next.code = `LCMS_CODE_DONE;
               end
            end
            ST_DONE: begin
               if (cmp.belowRecharge) begin
                  cur_next.mode = ST_CHECK;
                  cur_next.code = `LCMS_CODE_CHECK;
               end
            end
            default: begin
               cur_next.mode = ST_SLEEP;
               cur_next.code = `LCMS_CODE_NOINPUT;
            end
         endcase
      end

      // thermal loop with hysteresis: enter above loop-in, leave below loop-out
      if (cur_next.mode != ST_FASTCC) begin
         cur_next.thermal = 1'b0;
      end else if (cmp.dieLoopIn) begin
         cur_next.thermal = 1'b1;
      end else if (cmp.dieLoopOut) begin
         cur_next.thermal = 1'b0;
      end

      // drive commands follow the next mode so they change with it
      cur_next.drive.pct = `LCMS_PCT_OFF;
      cur_next.drive.cvOn = 1'b0;
      cur_next.drive.regMv = `LCMS_REG_MV;
      cur_next.drive.rchMv = cur_reg.drive.rchMv;
      case (cur_next.mode)
         ST_PRECOND: cur_next.drive.pct = `LCMS_PCT_TRICKLE;
         ST_FASTCC: begin
            // reduced step only; finer creep-back is left to the analog loop
            cur_next.drive.pct = cur_next.thermal ? `LCMS_PCT_THERMAL : `LCMS_PCT_FULL;
         end
         ST_CONSTV: begin
            cur_next.drive.pct = `LCMS_PCT_FULL;
            cur_next.drive.cvOn = 1'b1;
         end
         ST_DONE: begin
            // recharge level is the regulation point less the recharge drop
            cur_next.drive.rchMv = `LCMS_REG_MV - `LCMS_RCH_DROP_MV;
         end
         default: cur_next.drive.pct = `LCMS_PCT_OFF;
      endcase

      // leds: charging, done, both lit on fault
      cur_next.ledChg = 1'b0;
      cur_next.ledDone = 1'b0;
      case (cur_next.mode)
         ST_PRECOND, ST_FASTCC, ST_CONSTV: cur_next.ledChg = 1'b1;
         ST_DONE: cur_next.ledDone = 1'b1;
         ST_FAULT: begin
            cur_next.ledChg = 1'b1;
            cur_next.ledDone = 1'b1;
         end
         default: cur_next.ledChg = 1'b0;
      endcase
   end

   // one register for the whole state
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // serial status report; own drive is ignored by the shifter while it sends
   lcms_status_tx #(
      .BIT_CYC(BIT_CYC),
      .REQ_CYC(12'(`LCMS_REQ_MIN_CYC))
   ) u_tx (
      .clk(clk),
      .rst_b(rst_b),
      .lineLow(cur_reg.reqS2),
      .code(cur_reg.code),
      .lineOe(txOe),
      .busy(txBusy)
   );

   // outputs
   assign statusOut = 1'b0;
   assign statusOe = txOe;
   assign drive = cur_reg.drive;
   assign ledCharge_b = !cur_reg.ledChg;
   assign ledDone_b = !cur_reg.ledDone;

   // helper: position inside one report bit, wrapping at the bit period on its own
   logic [11:0] astBitCnt;
   always_ff @(posedge clk) begin
      if (!rst_b || !txBusy || astBitCnt == BIT_CYC - 12'h001) begin
         astBitCnt <= 12'h000;
      end else begin
         astBitCnt <= astBitCnt + 12'h001;
      end
   end

   AST_NO_START_LOW_SUPPLY: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_CHECK && !cmp.adpOk) |=> (cur_reg.mode == ST_SLEEP && drive.pct == `LCMS_PCT_OFF))
      else $error("charge started below lockout");

   AST_TEMP_GATE: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_CHECK && !cmp.tempOk) |=> !(cur_reg.mode inside {ST_PRECOND, ST_FASTCC, ST_CONSTV}))
      else $error("charge started outside temperature window");

   AST_PRECOND_ENTRY: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_CHECK && healthy && cmp.cellPresent && cmp.belowPrecond)
      |=> (cur_reg.mode == ST_PRECOND && drive.pct == `LCMS_PCT_TRICKLE))
      else $error("low cell did not enter preconditioning");

   AST_TRICKLE_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_PRECOND) |-> (drive.pct == `LCMS_PCT_TRICKLE && ledCharge_b == 1'b0))
      else $error("trickle level wrong");

   AST_PRECOND_EXIT: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_PRECOND && healthy && !cmp.belowPrecond) |=> (cur_reg.mode == ST_FASTCC))
      else $error("preconditioning did not end");

   AST_CC_TO_CV: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_FASTCC && healthy && cmp.atRegulation) |=> (cur_reg.mode == ST_CONSTV && drive.cvOn))
      else $error("no switch to constant voltage");

   AST_CV_SETPOINT: assert property (@(posedge clk) disable iff (!rst_b)
      drive.cvOn |-> (cur_reg.mode == ST_CONSTV && drive.regMv == `LCMS_REG_MV))
      else $error("voltage loop setpoint wrong");

   AST_TERMINATE: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_CONSTV && healthy && cmp.belowTerm)
      |=> (cur_reg.mode == ST_DONE && drive.pct == `LCMS_PCT_OFF && !ledDone_b))
      else $error("charge not terminated");

   AST_RECHARGE: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_DONE && healthy && cmp.belowRecharge) |=> cur_reg.mode == ST_CHECK ##1
      (cur_reg.mode != ST_DONE))
      else $error("recharge did not start");

   AST_RCH_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_DONE) |-> (drive.rchMv == `LCMS_REG_MV - `LCMS_RCH_DROP_MV))
      else $error("recharge level wrong");

   AST_SUPPLY_LOSS: assert property (@(posedge clk) disable iff (!rst_b)
      (!cmp.adpOk) |=> (cur_reg.mode == ST_SLEEP && cur_reg.code == `LCMS_CODE_NOINPUT))
      else $error("no sleep on supply loss");

   AST_RESUME: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_SLEEP && healthy) |=> (cur_reg.mode == ST_CHECK))
      else $error("no resume after supply recovery");

   AST_THERMAL_CUT: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_FASTCC && cmp.dieLoopIn && healthy && !cmp.atRegulation)
      |=> (drive.pct == `LCMS_PCT_THERMAL))
      else $error("thermal loop did not cut current");

   AST_THERMAL_RESTORE: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_FASTCC && cmp.dieLoopOut && !cmp.dieLoopIn && healthy && !cmp.atRegulation)
      |=> (drive.pct == `LCMS_PCT_FULL))
      else $error("full current not restored");

   AST_FAULT_STOP: assert property (@(posedge clk) disable iff (!rst_b)
      (cmp.adpOk && cmp.enable && (cmp.overVoltage || cmp.dieShutdown))
      |=> (cur_reg.mode == ST_FAULT && drive.pct == `LCMS_PCT_OFF))
      else $error("fault did not stop charging");

   AST_CELL_HOT: assert property (@(posedge clk) disable iff (!rst_b)
      (cmp.adpOk && cmp.enable && !cmp.tempOk) |=> (drive.pct == `LCMS_PCT_OFF))
      else $error("cell temperature fault ignored");

   AST_FAULT_REPORT: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_FAULT) |-> (!ledCharge_b && !ledDone_b && cur_reg.code >= `LCMS_CODE_OVERVOLT))
      else $error("fault not reported");

   AST_CODE_RANGE: assert property (@(posedge clk) disable iff (!rst_b)
      cur_reg.code <= `LCMS_CODE_NOCELL)
      else $error("status code out of range");

   AST_BIT_RATE: assert property (@(posedge clk) disable iff (!rst_b)
      (txBusy && $changed(txOe)) |-> (astBitCnt == 12'h000))
      else $error("report bit edge off the bit period");

   AST_START_BIT: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(txBusy) |-> txOe)
      else $error("report frame without start bit");

   AST_NO_CELL_WAIT: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_CHECK && healthy && !cmp.cellPresent)
      |=> (cur_reg.mode == ST_CHECK && cur_reg.code == `LCMS_CODE_NOCELL && drive.pct == `LCMS_PCT_OFF))
      else $error("charging without a cell");

   AST_LED_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode inside {ST_SLEEP, ST_CHECK}) |-> (ledCharge_b && ledDone_b))
      else $error("led lit while not charging");

   AST_PRECOND_ORDER: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_PRECOND) |=> !(cur_reg.mode inside {ST_CHECK, ST_CONSTV, ST_DONE}))
      else $error("preconditioning skipped fast charge");

   AST_CV_ORDER: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_CONSTV) |=> !(cur_reg.mode inside {ST_CHECK, ST_PRECOND, ST_FASTCC}))
      else $error("constant voltage stepped backwards");

   AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (!rst_b)
      (cur_reg.mode == ST_FASTCC && $rose(cmpPins.overVoltage) && cmpPins.adpOk) |=> (cur_reg.mode != ST_FAULT))
      else $error("raw comparator used without synchroniser");
endmodule // lcms_charge_sequencer

// >>> lcms_consts.svh
// timing, level and status-code constants of the charge mode sequencer
`ifndef LCMS_CONSTS_SVH
`define LCMS_CONSTS_SVH
`define LCMS_CLK_HZ 40000000
`define LCMS_REQ_MIN_NS 200
`define LCMS_REQ_MIN_CYC ((`LCMS_REQ_MIN_NS * (`LCMS_CLK_HZ / 1000000) + 999) / 1000)
`define LCMS_DATA_HZ 20000
`define LCMS_BIT_CYC (`LCMS_CLK_HZ / `LCMS_DATA_HZ)
`define LCMS_FRAME_BITS 5
`define LCMS_PCT_OFF 7'h00
`define LCMS_PCT_FULL 7'h64
`define LCMS_PCT_TRICKLE 7'h0a
`define LCMS_PCT_THERMAL 7'h2c
`define LCMS_REG_MV 13'h1068
`define LCMS_RCH_DROP_MV 13'h0064
`define LCMS_CODE_CHECK 4'h0
`define LCMS_CODE_PRECOND 4'h1
`define LCMS_CODE_FASTCC 4'h2
`define LCMS_CODE_THERMAL 4'h3
`define LCMS_CODE_CONSTV 4'h4
`define LCMS_CODE_DONE 4'h5
`define LCMS_CODE_NOINPUT 4'h6
`define LCMS_CODE_DISABLED 4'h7
`define LCMS_CODE_OVERVOLT 4'h8
`define LCMS_CODE_DIEHOT 4'h9
`define LCMS_CODE_CELLTEMP 4'ha
`define LCMS_CODE_NOCELL 4'hb
`endif

// >>> lcms_pkg.sv
// types shared by the charge mode sequencer and its status transmitter
package lcms_pkg;
   typedef enum logic [2:0] {ST_SLEEP, ST_CHECK, ST_PRECOND, ST_FASTCC, ST_CONSTV, ST_DONE, ST_FAULT} lcms_mode_t;
   typedef enum logic [1:0] {TX_IDLE, TX_REQ, TX_WAIT, TX_SEND} lcms_tx_phase_t;
   // comparator outputs, all asynchronous to clk
   typedef struct packed {
      logic adpOk;
      logic enable;
      logic tempOk;
      logic cellPresent;
      logic belowPrecond;
      logic atRegulation;
      logic belowTerm;
      logic belowRecharge;
      logic overVoltage;
      logic dieLoopIn;
      logic dieLoopOut;
      logic dieShutdown;
   } lcms_cmp_t;
   // analog loop commands
   typedef struct packed {
      logic [6:0] pct;
      logic cvOn;
      logic [12:0] regMv;
      logic [12:0] rchMv;
   } lcms_drive_t;
   typedef struct packed {
      lcms_cmp_t sync1;
      lcms_cmp_t sync2;
      logic reqS1;
      logic reqS2;
      lcms_mode_t mode;
      logic thermal;
      logic [3:0] code;
      lcms_drive_t drive;
      logic ledChg;
      logic ledDone;
   } lcms_seq_state_t;
   typedef struct packed {
      lcms_tx_phase_t phase;
      logic [11:0] cnt;
      logic [2:0] bitIdx;
      logic [4:0] shreg;
      logic oe;
   } lcms_tx_state_t;
endpackage

// >>> lcms_status_tx.sv
// serial status report: request pulse detect and bit shifter
`include "lcms_consts.svh"

module lcms_status_tx #(
   parameter logic [11:0] BIT_CYC = 12'(`LCMS_BIT_CYC),
   parameter logic [11:0] REQ_CYC = 12'(`LCMS_REQ_MIN_CYC)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // synchronised line level and code to report
   input wire logic lineLow,
   input wire logic [3:0] code,
   // open-drain drive
   output logic lineOe,
   output logic busy
);
   import lcms_pkg::*;
   lcms_tx_state_t cur_reg, cur_next;

   // request low long enough, wait for release, then start bit and code msb first
   always_comb begin
      cur_next = cur_reg;
      case (cur_reg.phase)
         TX_IDLE: begin
            cur_next.cnt = 12'h000;
            if (lineLow) begin
               cur_next.phase = TX_REQ;
               cur_next.cnt = 12'h001;
            end
         end
         TX_REQ: begin
            if (!lineLow) begin
               cur_next.phase = TX_IDLE;
            end else if (cur_reg.cnt >= REQ_CYC - 12'h001) begin
               cur_next.phase = TX_WAIT;
            end else begin
               cur_next.cnt = cur_reg.cnt + 12'h001;
            end
         end
         TX_WAIT: begin
            // code latched at release so it is current when sent
            if (!lineLow) begin
               cur_next.phase = TX_SEND;
               cur_next.shreg = {1'b0, code};
               cur_next.bitIdx = 3'h0;
               cur_next.cnt = 12'h000;
               cur_next.oe = 1'b1;
            end
         end
         TX_SEND: begin
            if (cur_reg.cnt == BIT_CYC - 12'h001) begin
               cur_next.cnt = 12'h000;
               if (cur_reg.bitIdx == 3'(`LCMS_FRAME_BITS - 1)) begin
                  cur_next.phase = TX_IDLE;
                  cur_next.oe = 1'b0;
               end else begin
                  cur_next.bitIdx = cur_reg.bitIdx + 3'h1;
                  cur_next.shreg = {cur_reg.shreg[3:0], 1'b0};
                  cur_next.oe = !cur_reg.shreg[3];
               end
            end else begin
               cur_next.cnt = cur_reg.cnt + 12'h001;
            end
         end
         default: cur_next.phase = TX_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   assign lineOe = cur_reg.oe;
   assign busy = (cur_reg.phase == TX_SEND);
endmodule // lcms_status_tx

// >>> tb_top.sv
// self-checking bench for the charge mode sequencer
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import lcms_pkg::*;

   localparam logic [11:0] BIT = 12'h014; // short report bit to keep the run brief

   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic mcuLow = 1'b0;
   logic [12:0] cellMv = 13'h09c4; // deeply discharged, 2500 mV
   lcms_cmp_t env = '0;
   lcms_cmp_t cmpPins;
   lcms_drive_t drive;
   logic statusOut;
   logic statusOe;
   logic ledCharge_b;
   logic ledDone_b;
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   // status line has a pull-up: low if either party pulls
   wire statusIn = !(statusOe || mcuLow);

   always #12.5 clk = ~clk;

   lcms_charge_sequencer #(.BIT_CYC(BIT)) DUT (.clk(clk), .rst_b(rst_b), .cmpPins(cmpPins),
      .statusIn(statusIn), .statusOut(statusOut), .statusOe(statusOe), .drive(drive),
      .ledCharge_b(ledCharge_b), .ledDone_b(ledDone_b));

   lcms_cell_model CELL (.clk(clk), .rst_b(rst_b), .env(env), .cellMv(cellMv), .drive(drive),
      .cmpPins(cmpPins));

   task automatic final_report();
      if (errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // hang guard, well above the under two thousand cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         final_report();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_pct(input logic [6:0] exp);
      for (int i = 0; i < 20 && drive.pct !== exp; i++) tick(1);
   endtask

   // request a report and decode it, sampling each bit in its middle
   task automatic read_status(input logic [3:0] exp);
      logic [3:0] code;
      code = 4'h0;
      mcuLow = 1'b1;
      tick(10);
      mcuLow = 1'b0;
      for (int i = 0; i < 10 && statusOe !== 1'b1; i++) tick(1);
      chk("start bit", statusOe, 1'b1);
      tick(BIT - 1);
      chk("start width", statusOe, 1'b1);
      tick(BIT / 2 + 1);
      for (int k = 3; k >= 0; k--) begin
         code[k] = !statusOe;
         tick(BIT);
      end
      chk("status code", code, exp);
      chk("line data", statusOut, 1'b0);
      chk("frame end", statusOe, 1'b0);
   endtask

   task automatic t_start();
      tick(10);
      chk("pct cold cell", drive.pct, 7'h00);
      env.tempOk = 1'b1;
      env.adpOk = 1'b0;
      tick(10);
      chk("pct no supply", drive.pct, 7'h00);
      read_status(4'h6);
      env.adpOk = 1'b1;
   endtask

   task automatic t_cycle();
      wait_pct(7'h0a);
      chk("trickle pct", drive.pct, 7'h0a);
      chk("charge led", ledCharge_b, 1'b0);
      read_status(4'h1);
      cellMv = 13'h0dac; // 3500 mV
      wait_pct(7'h64);
      chk("fast pct", drive.pct, 7'h64);
      cellMv = 13'h1068; // 4200 mV
      for (int i = 0; i < 20 && drive.cvOn !== 1'b1; i++) tick(1);
      chk("cv on", drive.cvOn, 1'b1);
      chk("reg level", drive.regMv, 13'h1068);
      for (int i = 0; i < 60 && ledDone_b !== 1'b0; i++) tick(1);
      chk("done led", ledDone_b, 1'b0);
      chk("done pct", drive.pct, 7'h00);
      chk("recharge level", drive.rchMv, 13'h1068 - 13'h0064);
      cellMv = 13'h1036; // 4150 mV, above recharge level
      tick(20);
      chk("still done", ledDone_b, 1'b0);
      read_status(4'h5);
      cellMv = 13'h0fd2; // 4050 mV
      wait_pct(7'h64);
      chk("recharge pct", drive.pct, 7'h64);
   endtask

   task automatic t_thermal();
      env.dieLoopIn = 1'b1;
      wait_pct(7'h2c);
      chk("thermal pct", drive.pct, 7'h2c);
      read_status(4'h3);
      env.dieLoopIn = 1'b0;
      env.dieLoopOut = 1'b1;
      wait_pct(7'h64);
      chk("restored pct", drive.pct, 7'h64);
   endtask

   // each fault and each sleep cause in turn, with its report code
   task automatic t_faults();
      logic [3:0] codes [5] = '{4'h8, 4'h9, 4'ha, 4'h6, 4'h7};
      for (int i = 0; i < 5; i++) begin
         env.overVoltage = (i == 0);
         env.dieShutdown = (i == 1);
         env.tempOk = (i != 2);
         env.adpOk = (i != 3);
         env.enable = (i != 4);
         wait_pct(7'h00);
         tick(5);
         chk("fault pct", drive.pct, 7'h00);
         if (i < 3) begin
            chk("fault leds", {ledCharge_b, ledDone_b}, 2'b00);
         end
         read_status(codes[i]);
         env = '{adpOk: 1'b1, enable: 1'b1, tempOk: 1'b1, cellPresent: 1'b1, dieLoopOut: 1'b1, default: 1'b0};
         wait_pct(7'h64);
         chk("resume pct", drive.pct, 7'h64);
      end
   endtask

   // cell removed while disabled: check waits with no current and reports it
   task automatic t_nocell();
      env.enable = 1'b0;
      env.cellPresent = 1'b0;
      tick(5);
      env.enable = 1'b1;
      tick(5);
      chk("no cell pct", drive.pct, 7'h00);
      chk("no cell leds", {ledCharge_b, ledDone_b}, 2'b11);
      read_status(4'hb);
      env.cellPresent = 1'b1;
      wait_pct(7'h64);
      chk("cell back pct", drive.pct, 7'h64);
   endtask

   task automatic t_short();
      mcuLow = 1'b1;
      tick(4); // below the minimum request width
      mcuLow = 1'b0;
      tick(2 * BIT);
      chk("short request", statusOe, 1'b0);
   endtask

   initial begin
      env = '{adpOk: 1'b1, enable: 1'b1, cellPresent: 1'b1, dieLoopOut: 1'b1, default: 1'b0};
      tick(12);
      rst_b = 1'b1;
      t_start();
      t_cycle();
      t_thermal();
      t_faults();
      t_nocell();
      t_short();
      final_report();
   end
endmodule // tb_top
